// ===== inc/adcs_pkg.sv
// Package for the conversion sequencer: register map, fields, modes, timing.
// Assumes a single 250 MHz clock domain and an AHB-Lite slave port.
package adcs_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADCS_CTRL_OFS = 8'h00;
    localparam logic [7:0] ADCS_STAT_OFS = 8'h04;
    localparam logic [7:0] ADCS_RESULT_OFS = 8'h08;
    localparam logic [7:0] ADCS_RATE_OFS = 8'h0c;
    localparam logic [7:0] ADCS_MUX_OFS = 8'h10;

    // ----------------------------------------
    // Control and status fields
    // ----------------------------------------
    localparam int ADCS_CTRL_START_BIT = 0;
    localparam int ADCS_CTRL_MODE_LSB = 4;
    localparam int ADCS_CTRL_EN_BIT = 8;
    localparam int ADCS_STAT_DONE_BIT = 0;
    localparam int ADCS_STAT_BUSY_BIT = 1;
    localparam int ADCS_STAT_VALID_BIT = 2;
    localparam int ADCS_STAT_PRIME_LSB = 4;

    localparam logic [1:0] ADCS_MODE_RST = 2'h0;
    localparam logic [15:0] ADCS_RATE_RST = 16'h0010;
    localparam logic [2:0] ADCS_MUX_RST = 3'h0;

    // ----------------------------------------
    // Conversion timing
    // ----------------------------------------
    localparam int ADCS_CONV_NS = 64;
    localparam int ADCS_CLK_NS = 4;
    localparam int ADCS_CONV_CYC = (ADCS_CONV_NS + ADCS_CLK_NS - 1) / ADCS_CLK_NS;
    localparam logic [2:0] ADCS_PRIME_CNT = 3'h3;
    localparam logic [2:0] ADCS_BURST_CNT = 3'h4;

    typedef enum logic [1:0] {
        ADCS_SINGLE,
        ADCS_CONT,
        ADCS_MULTI,
        ADCS_MULTI_TURBO
    } adcs_mode_type;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } adcs_ahb_req_type;

endpackage

// ===== verilog/adcs_period.sv
// Conversion period divider: one-cycle tick every period_len cycles while running.
// Assumes period_len is at least one; clear restarts the count.
module adcs_period
    import adcs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic clear,
    input wire logic [15:0] period_len,
    output logic tick
);

    logic [15:0] cnt_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 16'h0000;
            tick <= 1'b0;
        end else if (clear || !run) begin
            cnt_r <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_r + 16'h0001 >= period_len) begin
            cnt_r <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tick <= 1'b0;
        end
    end

endmodule

// ===== verilog/adcs_seq.sv
// Conversion sequencer top: modes, decimator priming, trigger and done output.
// Assumes one clock, a modulator data word on mod_data sampled at each period tick,
// and a single AHB-Lite master.
//
// How it works
// [RULE1] Four modes; start by bit or trigger
// [RULE2] Done flag and output held until read
// [RULE3] Output invalid until fourth sample after mux change
// [RULE4] Single mode: one result per trigger
// [RULE5] Single mode waits in standby for trigger
// [RULE6] Single trigger runs four conversions back-to-back
// [RULE7] First three conversions only prime decimator
// [RULE8] Result valid and done after fourth
// [RULE9] Completion pollable in status register
// [RULE10] After result read, back to standby
// [RULE11] Continuous: first result after three priming conversions
// [RULE12] Continuous: one result per period, no re-prime
// [RULE13] Host keeps mux fixed in continuous mode
// [RULE14] Multi: reset and re-prime between samples
// [RULE15] Multi: next sample starts automatically
// [RULE16] Trigger may come from clock or logic
// [RULE17] Continuous works with trigger unconnected
// [RULE18] Done rises at every conversion end; the code sets it only at result conversions, not at the three priming ones
// [RULE19] Trigger synchronised; rising edge starts burst
// [RULE20] Mode sampled only in standby
// [RULE21] Reset: standby, done low, count zero
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
module adcs_seq
    import adcs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic start_trig,
    input wire logic [15:0] mod_data,
    output logic conv_done,
    output logic [2:0] mux_sel,
    output logic mod_reset
);

    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_CONVERT,
        ST_HOLD
    } adcs_state_type;

    adcs_state_type state_r;
    adcs_mode_type mode_r;
    adcs_mode_type mode_cfg_r;
    adcs_ahb_req_type req_r;
    logic trig_s1_r;
    logic trig_s2_r;
    logic trig_d_r;
    logic start_bit_r;
    logic enable_r;
    logic done_r;
    logic valid_r;
    logic [2:0] prime_r;
    logic [2:0] since_mux_r;
    logic [15:0] rate_r;
    logic [15:0] result_r;
    logic [15:0] hist_r [0:2];
    logic tick;
    logic start_ev;
    logic rd_result;
    logic wr_ctrl;
    logic wr_mux;
    logic [17:0] sum4;

    // ----------------------------------------
    // Trigger synchroniser and start event
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_d_r <= 1'b0;
        end else begin
            trig_s1_r <= start_trig;
            trig_s2_r <= trig_s1_r;
            trig_d_r <= trig_s2_r; // RULE19
        end
    end

    // Held-high trigger gives one edge, hence one burst
    assign start_ev = (trig_s2_r && !trig_d_r) || start_bit_r; // RULE1 RULE19

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    assign wr_ctrl = req_r.hsel && req_r.hwrite && req_r.haddr[7:0] == ADCS_CTRL_OFS;
    assign wr_mux = req_r.hsel && req_r.hwrite && req_r.haddr[7:0] == ADCS_MUX_OFS;
    assign rd_result = hsel && hready && htrans[1] && !hwrite
        && haddr[7:0] == ADCS_RESULT_OFS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
        end else if (hready) begin
            req_r.hsel <= hsel && htrans[1];
            req_r.haddr <= haddr;
            req_r.hwrite <= hwrite;
            req_r.htrans <= htrans;
            req_r.hsize <= hsize;
            req_r.hready <= hready;
        end
    end

    // Zero-wait slave; response is always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                ADCS_CTRL_OFS: hrdata <= {23'h0, enable_r, 2'h0, mode_cfg_r, 4'h0};
                ADCS_STAT_OFS: hrdata <= {25'h0, prime_r, 1'b0, valid_r,
                    state_r != ST_STANDBY, done_r}; // RULE9
                ADCS_RESULT_OFS: hrdata <= {16'h0, result_r};
                ADCS_RATE_OFS: hrdata <= {16'h0, rate_r};
                ADCS_MUX_OFS: hrdata <= {29'h0, mux_sel};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_cfg_r <= adcs_mode_type'(ADCS_MODE_RST);
            enable_r <= 1'b0;
            start_bit_r <= 1'b0;
        end else if (wr_ctrl) begin
            mode_cfg_r <= adcs_mode_type'(hwdata[ADCS_CTRL_MODE_LSB +: 2]);
            enable_r <= hwdata[ADCS_CTRL_EN_BIT];
            start_bit_r <= hwdata[ADCS_CTRL_START_BIT]; // RULE1
        end else begin
            start_bit_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_r <= ADCS_RATE_RST;
            mux_sel <= ADCS_MUX_RST;
        end else begin
            if (req_r.hsel && req_r.hwrite && req_r.haddr[7:0] == ADCS_RATE_OFS) begin
                // Zero is stored as one; the divider ticks every cycle for either value
                rate_r <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
            end
            if (wr_mux) begin
                mux_sel <= hwdata[2:0];
            end
        end
    end

    // ----------------------------------------
    // Conversion period and decimator
    // ----------------------------------------
    // Divider restarts with every modulator reset
    adcs_period u_period (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(state_r == ST_CONVERT),
        .clear(mod_reset),
        .period_len(rate_r),
        .tick(tick)
    );

    // Four-tap pipeline: output depends on the last four samples
    // Sample arriving with the tick is the fourth tap, so the 4th conversion counts
    assign sum4 = {2'b00, mod_data} + {2'b00, hist_r[0]} + {2'b00, hist_r[1]}
        + {2'b00, hist_r[2]};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_hist
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    hist_r[gi] <= 16'h0000;
                end else if (tick) begin
                    hist_r[gi] <= (gi == 0) ? mod_data : hist_r[(gi + 2) % 3];
                end
            end
        end
    endgenerate

    // Samples since last mux change or modulator reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_mux_r <= 3'h0;
        end else if (wr_mux || mod_reset) begin
            since_mux_r <= 3'h0; // RULE3
        end else if (tick && since_mux_r < ADCS_BURST_CNT) begin
            since_mux_r <= since_mux_r + 3'h1;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_STANDBY; // RULE21
            mode_r <= ADCS_SINGLE;
            prime_r <= 3'h0; // RULE21
            mod_reset <= 1'b1;
        end else begin
            mod_reset <= 1'b0;
            unique case (state_r)
                ST_STANDBY: begin
                    mod_reset <= 1'b1;
                    prime_r <= 3'h0;
                    // Mode latched here only; ignored mid-burst
                    mode_r <= mode_cfg_r; // RULE20
                    if (start_ev) begin
                        state_r <= ST_CONVERT; // RULE5 RULE4
                    end else if (enable_r && mode_cfg_r == ADCS_CONT) begin
                        state_r <= ST_CONVERT; // RULE17
                    end
                end
                ST_CONVERT: begin
                    // Stop requests wait for the next result tick
                    if (tick) begin
                        if (prime_r < ADCS_PRIME_CNT) begin
                            prime_r <= prime_r + 3'h1; // RULE6 RULE7 RULE11
                        end else if (mode_r == ADCS_SINGLE) begin
                            state_r <= ST_HOLD; // RULE8
                        end else if (mode_r == ADCS_CONT) begin
                            // Decimator stays primed
                            if (!enable_r) begin
                                state_r <= ST_STANDBY; // RULE12
                            end
                        end else begin
                            // Fresh sample starts at once
                            prime_r <= 3'h0; // RULE14 RULE15
                            mod_reset <= 1'b1; // RULE14
                            if (!enable_r) begin
                                state_r <= ST_STANDBY;
                            end
                        end
                    end
                end
                // Triggers arriving here are dropped until the result is read
                ST_HOLD: begin
                    if (rd_result) begin
                        state_r <= ST_STANDBY; // RULE10
                    end
                end
                default: state_r <= ST_STANDBY;
            endcase
        end
    end

    // ----------------------------------------
    // Result, done flag and done output
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_r <= 16'h0000;
            valid_r <= 1'b0;
        end else if (state_r == ST_CONVERT && tick && prime_r == ADCS_PRIME_CNT) begin
            result_r <= sum4[17:2];
            // Multi-sample mode primes through a fresh reset, so a mux change is covered
            valid_r <= (since_mux_r >= ADCS_PRIME_CNT) || mode_r != ADCS_CONT; // RULE3
        end else if (wr_mux) begin
            // Fresh input: no valid result until new samples fill the taps
            valid_r <= 1'b0; // RULE3
        end
    end

    // Set wins over a read in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r <= 1'b0; // RULE21
            conv_done <= 1'b0;
        end else if (state_r == ST_CONVERT && tick && prime_r == ADCS_PRIME_CNT) begin
            done_r <= 1'b1; // RULE2 RULE18
            conv_done <= 1'b1; // RULE8 RULE18
        end else if (rd_result) begin
            done_r <= 1'b0; // RULE2
            conv_done <= 1'b0;
        end
    end

endmodule

// ===== verif/adcs_seq_checker.sv
// Concurrent checks on the conversion sequencer's top-level ports.
// Assumes the single hclk domain and an active-low asynchronous hresetn.
module adcs_seq_checker
    import adcs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic conv_done,
    input wire logic [2:0] mux_sel,
    input wire logic mod_reset
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic take;
    logic rd_res;
    logic wr_mux;
    assign take = hsel && hready && htrans[1];
    assign rd_res = take && !hwrite && haddr[7:0] == ADCS_RESULT_OFS;
    assign wr_mux = take && hwrite && haddr[7:0] == ADCS_MUX_OFS;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    bus_ready_a: assert property (hreadyout)
        else $error("hreadyout low");
    bus_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    done_hold_a: assert property (conv_done && !rd_res && !$past(rd_res) |=> conv_done)
        else $error("done dropped without result read");
    done_fall_a: assert property ($fell(conv_done) |-> $past(rd_res) || $past(rd_res, 2))
        else $error("done fell with no read");
    reset_state_a: assert property ($rose(hresetn) |-> !conv_done && mod_reset)
        else $error("bad state after reset");
    // Decimator needs at least three clean cycles before a result
    prime_gap_a: assert property ($rose(conv_done) |->
        !$past(mod_reset) && !$past(mod_reset, 2) && !$past(mod_reset, 3))
        else $error("result too soon after modulator reset");
    mux_update_a: assert property ($changed(mux_sel) |-> $past(wr_mux, 2))
        else $error("mux select moved without write");
    rdata_hold_a: assert property ($changed(hrdata) |-> $past(take && !hwrite))
        else $error("read data moved without read");

    cover property ($rose(conv_done));
    cover property (rd_res && conv_done);
    cover property ($fell(mod_reset));
endmodule

// ===== verif/adcs_mod_model.sv
// Behavioural modulator feeding samples to the sequencer.
// Assumes the bench holds level steady while a conversion runs.
module adcs_mod_model (
    input wire logic mod_reset,
    input wire logic [15:0] level,
    output logic [15:0] mod_data
);
    // Held in reset the modulator gives junk, never the last level
    assign mod_data = mod_reset ? ~level : level;
endmodule

// ===== verif/adcs_conversion_sequencer_tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes the checker and modulator model files are compiled first.
module adcs_conversion_sequencer_tb
    import adcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [1:0] mode;
        logic trig;
        logic [15:0] level;
    } adcs_row_type;

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, start_trig;
    logic conv_done, mod_reset;
    logic [31:0] haddr, hwdata, hrdata, ctrl, d;
    logic [1:0] htrans;
    logic [2:0] hsize, mux_sel;
    logic [15:0] mod_data, level;
    adcs_row_type rows [5];
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;

    assign hready = hreadyout;

    adcs_seq u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .start_trig(start_trig),
        .mod_data(mod_data), .conv_done(conv_done), .mux_sel(mux_sel), .mod_reset(mod_reset));
    adcs_mod_model u_mod (.mod_reset(mod_reset), .level(level), .mod_data(mod_data));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (conv_done !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, conv_done}, 32'h1, "no end of conversion");
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Ceiling well above the several hundred cycles the run needs
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            close_out();
        end
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        start_trig = 1'b0;
        level = 16'h0;
        rows[0] = '{2'h0, 1'b1, 16'h1234};
        rows[1] = '{2'h0, 1'b0, 16'h0abc};
        rows[2] = '{2'h1, 1'b0, 16'h5555};
        rows[3] = '{2'h2, 1'b0, 16'h00f0};
        rows[4] = '{2'h3, 1'b0, 16'h7777};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b1, ADCS_RATE_OFS, 32'h4);
        xfer(1'b0, ADCS_RATE_OFS, 32'h0);
        chk(d, 32'h4, "rate readback");
        for (int i = 0; i < 5; i++) begin
            level <= rows[i].level;
            ctrl = {23'h0, 1'b1, 2'h0, rows[i].mode, 3'h0, !rows[i].trig && rows[i].mode != 2'h1};
            xfer(1'b1, ADCS_CTRL_OFS, ctrl);
            if (rows[i].trig) begin
                start_trig <= 1'b1;
                repeat (3) @(posedge hclk);
                start_trig <= 1'b0;
            end
            wait_done();
            xfer(1'b0, ADCS_STAT_OFS, 32'h0);
            chk(d & 32'h1, 32'h1, "status done bit");
            xfer(1'b0, ADCS_RESULT_OFS, 32'h0);
            chk({16'h0, d[15:0]}, {16'h0, rows[i].level}, "result");
            if (rows[i].mode == 2'h0) begin
                repeat (24) @(posedge hclk);
                chk({31'h0, conv_done}, 32'h0, "extra single result");
            end else begin
                wait_done();
                xfer(1'b0, ADCS_RESULT_OFS, 32'h0);
                chk({16'h0, d[15:0]}, {16'h0, rows[i].level}, "next result");
                xfer(1'b1, ADCS_CTRL_OFS, 32'h0);
                repeat (40) @(posedge hclk);
                xfer(1'b0, ADCS_RESULT_OFS, 32'h0);
            end
            $display("test %0d done", i);
        end
        // Held trigger must start only one burst
        xfer(1'b1, ADCS_CTRL_OFS, 32'h100);
        start_trig <= 1'b1;
        wait_done();
        xfer(1'b0, ADCS_RESULT_OFS, 32'h0);
        repeat (40) @(posedge hclk);
        chk({31'h0, conv_done}, 32'h0, "held trigger restarted");
        start_trig <= 1'b0;
        $display("test held trigger done");
        // Mux change then continuous with trigger idle
        xfer(1'b1, ADCS_MUX_OFS, 32'h6);
        @(posedge hclk);
        chk({29'h0, mux_sel}, 32'h6, "mux select");
        xfer(1'b1, ADCS_CTRL_OFS, 32'h110);
        xfer(1'b0, ADCS_STAT_OFS, 32'h0);
        chk(d & 32'h4, 32'h0, "valid too early");
        wait_done();
        xfer(1'b0, ADCS_STAT_OFS, 32'h0);
        chk(d & 32'h4, 32'h4, "valid missing");
        xfer(1'b1, ADCS_CTRL_OFS, 32'h0);
        repeat (40) @(posedge hclk);
        xfer(1'b0, ADCS_RESULT_OFS, 32'h0);
        xfer(1'b1, 8'h20, 32'h5a5a5a5a);
        xfer(1'b0, 8'h20, 32'h0);
        chk(d, 32'h0, "unmapped read");
        $display("test mux and map done");
        // Reset in the middle of a burst
        xfer(1'b1, ADCS_CTRL_OFS, 32'h101);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({30'h0, conv_done, mod_reset}, 32'h1, "state in reset");
        hresetn <= 1'b1;
        xfer(1'b0, ADCS_STAT_OFS, 32'h0);
        chk(d & 32'h71, 32'h0, "status after reset");
        $display("test mid reset done");
        close_out();
    end
endmodule

bind adcs_seq adcs_seq_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done), .mux_sel(mux_sel),
    .mod_reset(mod_reset));
